// ===== hw/ppo_top.sv
// Pin pair output control with its AHB-Lite register slave
//
// Overview of operation
// - High pin inverted when its polarity is set
// - Low pin inverted when bit 12 set
// - Mode bits 11-10 only act in redundant (1), which copies the high generator to the low pin
// - High override enable picks override bit 1
// - Low override enable picks override bit 0
// - Override value field held at bits 7-6
// - Active fault drives fault state bits 5-4
//
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
module ppo_top (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Generator side, same clock domain
  input wire logic gen_high_in,
  input wire logic gen_low_in,
  input wire logic fault_active_in,
  // Pins to the power stage
  output logic high_side_pin_out,
  output logic low_side_pin_out
);

  typedef struct packed {
    logic high_pol;
    logic low_pol;
    logic [1:0] mode;
    logic ovr_en_h;
    logic ovr_en_l;
    logic [1:0] ovr_val;
    logic [1:0] flt_val;
    logic ind_flt;
    logic [1:0] flt_mode;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic ready;
  } ppo_regs_t;

  ppo_regs_t r_reg;
  ppo_regs_t r_next;
  ppo_stage_if st_if ();

  // Pack the pair control word from the register state
  function automatic logic [31:0] pair_word(input ppo_regs_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ppo_pkg::POS_HIGH_POL] = s.high_pol;
    w[ppo_pkg::POS_LOW_POL] = s.low_pol;
    w[ppo_pkg::POS_MODE +: 2] = s.mode;
    w[ppo_pkg::POS_OVR_EN_H] = s.ovr_en_h;
    w[ppo_pkg::POS_OVR_EN_L] = s.ovr_en_l;
    w[ppo_pkg::POS_OVR_VAL +: 2] = s.ovr_val;
    w[ppo_pkg::POS_FLT_VAL +: 2] = s.flt_val;
    return w;
  endfunction

  function automatic logic [31:0] fault_word(input ppo_regs_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ppo_pkg::POS_IND_FLT] = s.ind_flt;
    w[ppo_pkg::POS_FLT_MODE +: 2] = s.flt_mode;
    return w;
  endfunction

  // Load the pair control word, used at reset and on bus writes
  function automatic ppo_regs_t load_pair(input ppo_regs_t s, input logic [31:0] w);
    ppo_regs_t n;
    n = s;
    n.high_pol = w[ppo_pkg::POS_HIGH_POL];
    n.low_pol = w[ppo_pkg::POS_LOW_POL];
    n.mode = w[ppo_pkg::POS_MODE +: 2];
    n.ovr_en_h = w[ppo_pkg::POS_OVR_EN_H];
    n.ovr_en_l = w[ppo_pkg::POS_OVR_EN_L];
    n.ovr_val = w[ppo_pkg::POS_OVR_VAL +: 2];
    n.flt_val = w[ppo_pkg::POS_FLT_VAL +: 2];
    return n;
  endfunction

  function automatic ppo_regs_t load_fault(input ppo_regs_t s, input logic [31:0] w);
    ppo_regs_t n;
    n = s;
    n.ind_flt = w[ppo_pkg::POS_IND_FLT];
    n.flt_mode = w[ppo_pkg::POS_FLT_MODE +: 2];
    return n;
  endfunction

  function automatic ppo_regs_t reset_state();
    ppo_regs_t n;
    n = '0;
    n = load_pair(n, ppo_pkg::PAIR_CTRL_RST);
    n = load_fault(n, ppo_pkg::FAULT_CTRL_RST);
    return n;
  endfunction

  localparam ppo_regs_t REGS_RST = reset_state();

  always_comb begin
    logic addr_ok;
    logic [31:0] status;
    logic [7:0] a;
    addr_ok = hsel_in & hready_in & htrans_in[1];
    a = haddr_in[7:0];
    status = 32'h0000_0000;
    status[ppo_pkg::POS_ST_PIN_H] = st_if.high_side_pin;
    status[ppo_pkg::POS_ST_PIN_L] = st_if.low_side_pin;
    status[ppo_pkg::POS_ST_FAULT] = fault_active_in;
    status[ppo_pkg::POS_ST_GEN_H] = gen_high_in;
    status[ppo_pkg::POS_ST_GEN_L] = gen_low_in;
    r_next = r_reg;
    r_next.ready = 1'b1;
    // Data phase of a write: commit the word
    if (r_reg.wr_pend) begin
      case (r_reg.wr_addr)
        ppo_pkg::OFS_PAIR_CTRL: r_next = load_pair(r_next, hwdata_in);
        ppo_pkg::OFS_FAULT_CTRL: r_next = load_fault(r_next, hwdata_in);
        default: r_next = r_next;
      endcase
    end
    r_next.wr_pend = addr_ok & hwrite_in;
    r_next.wr_addr = a;
    // Read data taken from the updated copy, so a read right after a write sees it
    if (addr_ok && !hwrite_in) begin
      case (a)
        ppo_pkg::OFS_PAIR_CTRL: r_next.rdata = pair_word(r_next);
        ppo_pkg::OFS_FAULT_CTRL: r_next.rdata = fault_word(r_next);
        ppo_pkg::OFS_STATUS: r_next.rdata = status;
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r_reg <= REGS_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Stage inputs
  assign st_if.gen_high = gen_high_in;
  assign st_if.gen_low = gen_low_in;
  assign st_if.fault_active = fault_active_in;
  // Independent fault mode is stored only; current limit logic lives elsewhere
  assign st_if.fault_enable = (r_reg.flt_mode != ppo_pkg::FLT_MODE_DISABLED);
  assign st_if.high_pin_polarity = r_reg.high_pol;
  assign st_if.low_pin_polarity = r_reg.low_pol;
  assign st_if.pin_pair_mode = ppo_pkg::ppo_mode_t'(r_reg.mode);
  assign st_if.high_pin_override_enable = r_reg.ovr_en_h;
  assign st_if.low_pin_override_enable = r_reg.ovr_en_l;
  assign st_if.override_value = r_reg.ovr_val;
  assign st_if.fault_state_value = r_reg.flt_val;

  ppo_pin_stage u_stage (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .st(st_if.stage)
  );

  assign hrdata_out = r_reg.rdata;
  assign hreadyout_out = r_reg.ready;
  assign hresp_out = ppo_pkg::HRESP_OKAY;
  assign high_side_pin_out = st_if.high_side_pin;
  assign low_side_pin_out = st_if.low_side_pin;

  // Checks on the pin path, one cycle of stage latency, then mode write and bus ready checks
  logic fault_on;
  assign fault_on = fault_active_in & st_if.fault_enable;

  a_high_gen_pol: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (!fault_on && !r_reg.ovr_en_h) |=>
      high_side_pin_out == ($past(gen_high_in) ^ $past(r_reg.high_pol)))
    else $error("high pin does not follow generator with polarity");

  a_low_gen_pol: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (!fault_on && !r_reg.ovr_en_l && r_reg.mode != ppo_pkg::PPO_REDUNDANT) |=>
      low_side_pin_out == ($past(gen_low_in) ^ $past(r_reg.low_pol)))
    else $error("low pin does not follow generator with polarity");

  a_redundant_copy: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (!fault_on && !r_reg.ovr_en_l && r_reg.mode == ppo_pkg::PPO_REDUNDANT) |=>
      low_side_pin_out == ($past(gen_high_in) ^ $past(r_reg.low_pol)))
    else $error("redundant mode does not copy high drive to low pin");

  a_high_override: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (!fault_on && r_reg.ovr_en_h) |=>
      high_side_pin_out == ($past(r_reg.ovr_val[1]) ^ $past(r_reg.high_pol)))
    else $error("high override value not on pin");

  a_low_override: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (!fault_on && r_reg.ovr_en_l) |=>
      low_side_pin_out == ($past(r_reg.ovr_val[0]) ^ $past(r_reg.low_pol)))
    else $error("low override value not on pin");

  a_override_field: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (r_reg.wr_pend && r_reg.wr_addr == ppo_pkg::OFS_PAIR_CTRL) |=>
      (r_reg.ovr_val == $past(hwdata_in[ppo_pkg::POS_OVR_VAL +: 2])) and
      (##1 (!fault_on && r_reg.ovr_en_h && r_reg.ovr_en_l) |->
        ##1 {high_side_pin_out, low_side_pin_out} ==
          ($past(r_reg.ovr_val) ^ {$past(r_reg.high_pol), $past(r_reg.low_pol)})))
    else $error("override field write not carried to pins");

  a_fault_state: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    fault_on |=> {high_side_pin_out, low_side_pin_out} ==
      ($past(r_reg.flt_val) ^ {$past(r_reg.high_pol), $past(r_reg.low_pol)}))
    else $error("fault state not driven while fault active");

  a_fault_priority: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (fault_on && r_reg.ovr_en_h && r_reg.flt_val[1] != r_reg.ovr_val[1]) |=>
      high_side_pin_out != ($past(r_reg.ovr_val[1]) ^ $past(r_reg.high_pol)))
    else $error("override won over fault state");

  a_mode_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (r_reg.wr_pend && r_reg.wr_addr == ppo_pkg::OFS_PAIR_CTRL) |=>
      r_reg.mode == $past(hwdata_in[ppo_pkg::POS_MODE +: 2]))
    else $error("mode field not written");

  a_bus_ready: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $rose(rst_n_in) ##1 1'b1 |-> hreadyout_out)
    else $error("slave stalled the bus");

  // Register write checks, with the low side fault priority and disabled fault checks
  a_high_pol_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (r_reg.wr_pend && r_reg.wr_addr == ppo_pkg::OFS_PAIR_CTRL) |=>
      r_reg.high_pol == $past(hwdata_in[ppo_pkg::POS_HIGH_POL]))
    else $error("high polarity bit not written");

  a_low_pol_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (r_reg.wr_pend && r_reg.wr_addr == ppo_pkg::OFS_PAIR_CTRL) |=>
      r_reg.low_pol == $past(hwdata_in[ppo_pkg::POS_LOW_POL]))
    else $error("low polarity bit not written");

  a_ovr_en_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (r_reg.wr_pend && r_reg.wr_addr == ppo_pkg::OFS_PAIR_CTRL) |=>
      {r_reg.ovr_en_h, r_reg.ovr_en_l} == $past(hwdata_in[ppo_pkg::POS_OVR_EN_L +: 2]))
    else $error("override enables not written");

  a_fault_val_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (r_reg.wr_pend && r_reg.wr_addr == ppo_pkg::OFS_PAIR_CTRL) |=>
      r_reg.flt_val == $past(hwdata_in[ppo_pkg::POS_FLT_VAL +: 2]))
    else $error("fault state field not written");

  a_fault_mode_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (r_reg.wr_pend && r_reg.wr_addr == ppo_pkg::OFS_FAULT_CTRL) |=>
      r_reg.flt_mode == $past(hwdata_in[ppo_pkg::POS_FLT_MODE +: 2]))
    else $error("fault handling mode not written");

  a_ind_mode_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (r_reg.wr_pend && r_reg.wr_addr == ppo_pkg::OFS_FAULT_CTRL) |=>
      r_reg.ind_flt == $past(hwdata_in[ppo_pkg::POS_IND_FLT]))
    else $error("independent fault mode bit not written");

  a_low_fault_priority: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (fault_on && r_reg.ovr_en_l && r_reg.flt_val[0] != r_reg.ovr_val[0]) |=>
      low_side_pin_out != ($past(r_reg.ovr_val[0]) ^ $past(r_reg.low_pol)))
    else $error("low override won over fault state");

  a_fault_disabled: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (fault_active_in && r_reg.flt_mode == ppo_pkg::FLT_MODE_DISABLED &&
      !r_reg.ovr_en_h) |=>
      high_side_pin_out == ($past(gen_high_in) ^ $past(r_reg.high_pol)))
    else $error("fault state driven although faults are disabled");

  a_unmapped_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (r_reg.wr_pend && r_reg.wr_addr != ppo_pkg::OFS_PAIR_CTRL &&
      r_reg.wr_addr != ppo_pkg::OFS_FAULT_CTRL) |=>
      $stable({r_reg.high_pol, r_reg.low_pol, r_reg.mode, r_reg.ovr_en_h, r_reg.ovr_en_l,
        r_reg.ovr_val, r_reg.flt_val, r_reg.ind_flt, r_reg.flt_mode}))
    else $error("write to unmapped offset changed a control field");

  // Read-back checks; a pending write is left out since it lands first
  a_read_override: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (hsel_in && hready_in && htrans_in[1] && !hwrite_in && !r_reg.wr_pend &&
      haddr_in[7:0] == ppo_pkg::OFS_PAIR_CTRL) |=>
      hrdata_out[ppo_pkg::POS_OVR_VAL +: 2] == $past(r_reg.ovr_val))
    else $error("override field read back wrong");

  a_read_mode: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (hsel_in && hready_in && htrans_in[1] && !hwrite_in && !r_reg.wr_pend &&
      haddr_in[7:0] == ppo_pkg::OFS_PAIR_CTRL) |=>
      hrdata_out[ppo_pkg::POS_MODE +: 2] == $past(r_reg.mode))
    else $error("mode field read back wrong");

  a_read_polarity: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (hsel_in && hready_in && htrans_in[1] && !hwrite_in && !r_reg.wr_pend &&
      haddr_in[7:0] == ppo_pkg::OFS_PAIR_CTRL) |=>
      {hrdata_out[ppo_pkg::POS_HIGH_POL], hrdata_out[ppo_pkg::POS_LOW_POL]} ==
        $past({r_reg.high_pol, r_reg.low_pol}))
    else $error("polarity bits read back wrong");

  a_read_status: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (hsel_in && hready_in && htrans_in[1] && !hwrite_in &&
      haddr_in[7:0] == ppo_pkg::OFS_STATUS) |=>
      hrdata_out[ppo_pkg::POS_ST_PIN_H] == $past(high_side_pin_out) &&
      hrdata_out[ppo_pkg::POS_ST_PIN_L] == $past(low_side_pin_out))
    else $error("status read does not show the pins");

  a_ready_held: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    hreadyout_out |=> hreadyout_out)
    else $error("slave inserted a wait state");

endmodule // ppo_top

// ===== shared/ppo_pkg.sv
// Constants shared by the pin pair output control block
package ppo_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_PAIR_CTRL = 8'h00;
  localparam logic [7:0] OFS_FAULT_CTRL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // Pair control register fields
  localparam int POS_HIGH_POL = 13;
  localparam int POS_LOW_POL = 12;
  localparam int POS_MODE = 10;
  localparam int POS_OVR_EN_H = 9;
  localparam int POS_OVR_EN_L = 8;
  localparam int POS_OVR_VAL = 6;
  localparam int POS_FLT_VAL = 4;

  // Fault control register fields
  localparam int POS_IND_FLT = 15;
  localparam int POS_FLT_MODE = 0;

  // Status register fields
  localparam int POS_ST_PIN_H = 0;
  localparam int POS_ST_PIN_L = 1;
  localparam int POS_ST_FAULT = 2;
  localparam int POS_ST_GEN_H = 3;
  localparam int POS_ST_GEN_L = 4;

  // Reset values
  localparam logic [31:0] PAIR_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] FAULT_CTRL_RST = 32'h0000_0003;

  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'h0;

  // Pin pair arrangement
  typedef enum logic [1:0] {
    PPO_COMPLEMENTARY = 2'h0,
    PPO_REDUNDANT = 2'h1,
    PPO_PUSH_PULL = 2'h2,
    PPO_INDEPENDENT = 2'h3
  } ppo_mode_t;

  // Fault handling mode; disabled ignores the fault input
  localparam logic [1:0] FLT_MODE_DISABLED = 2'h3;

endpackage

// ===== shared/ppo_stage_if.sv
// Carrier between the register side and the pin output stage
`timescale 1ns/1ps
interface ppo_stage_if;
  logic gen_high;
  logic gen_low;
  logic fault_active;
  logic fault_enable;
  logic high_pin_polarity;
  logic low_pin_polarity;
  ppo_pkg::ppo_mode_t pin_pair_mode;
  logic high_pin_override_enable;
  logic low_pin_override_enable;
  logic [1:0] override_value;
  logic [1:0] fault_state_value;
  logic high_side_pin;
  logic low_side_pin;

  modport ctrl (
    output gen_high, gen_low, fault_active, fault_enable,
    output high_pin_polarity, low_pin_polarity, pin_pair_mode,
    output high_pin_override_enable, low_pin_override_enable,
    output override_value, fault_state_value,
    input high_side_pin, low_side_pin
  );

  modport stage (
    input gen_high, gen_low, fault_active, fault_enable,
    input high_pin_polarity, low_pin_polarity, pin_pair_mode,
    input high_pin_override_enable, low_pin_override_enable,
    input override_value, fault_state_value,
    output high_side_pin, low_side_pin
  );
endinterface

// ===== hw/ppo_pin_stage.sv
// Pin output stage: fault, override and generator select, then polarity
`timescale 1ns/1ps
module ppo_pin_stage (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Link to the register side
  ppo_stage_if.stage st
);

  typedef struct packed {
    logic high_pin;
    logic low_pin;
  } ppo_pins_t;

  ppo_pins_t pins_reg;
  ppo_pins_t pins_next;

  always_comb begin
    logic fault_on;
    logic high_val;
    logic low_gen;
    logic low_val;
    fault_on = st.fault_active & st.fault_enable;
    // Redundant copies the high side generator onto the low pin
    low_gen = (st.pin_pair_mode == ppo_pkg::PPO_REDUNDANT) ? st.gen_high : st.gen_low;
    high_val = st.high_pin_override_enable ? st.override_value[1] : st.gen_high;
    low_val = st.low_pin_override_enable ? st.override_value[0] : low_gen;
    if (fault_on) begin
      high_val = st.fault_state_value[1];
      low_val = st.fault_state_value[0];
    end
    pins_next = pins_reg;
    pins_next.high_pin = high_val ^ st.high_pin_polarity;
    pins_next.low_pin = low_val ^ st.low_pin_polarity;
  end

  // Reset drives both pins low, the inactive level for reset polarity
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pins_reg <= '0;
    end else begin
      pins_reg <= pins_next;
    end
  end

  assign st.high_side_pin = pins_reg.high_pin;
  assign st.low_side_pin = pins_reg.low_pin;

endmodule // ppo_pin_stage

// ===== tb/ppo_power_stage.sv
// Behavioural power stage hanging on the pin pair
`timescale 1ns/1ps
module ppo_power_stage (
  // Clock
  input wire logic clock_in,
  // Pins from the device
  input wire logic high_side_pin_in,
  input wire logic low_side_pin_in,
  // Gate levels as latched by the drivers
  output logic high_gate_out,
  output logic low_gate_out
);
  // Passive load: it never drives back into the device
  always_ff @(posedge clock_in) begin
    high_gate_out <= high_side_pin_in;
    low_gate_out <= low_side_pin_in;
  end
endmodule // ppo_power_stage

// ===== tb/ppo_top_bench.sv
// Self-checking bench for the pin pair output control
`timescale 1ns/1ps
module ppo_top_bench;
  logic clock_in, rst_n_in, hsel, hwrite, gh, gl, flt, hready, hresp;
  logic pin_h, pin_l, gate_h, gate_l;
  logic [31:0] haddr, hwdata, hrdata, rd, ctrl, fctl, c, f;
  logic [1:0] htrans;
  logic [2:0] hsize;
  integer seed;
  int n_mismatch, total_checks, i, m;

  ppo_top dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .gen_high_in(gh), .gen_low_in(gl),
    .fault_active_in(flt), .high_side_pin_out(pin_h), .low_side_pin_out(pin_l));

  ppo_power_stage load_u (.clock_in(clock_in), .high_side_pin_in(pin_h),
    .low_side_pin_in(pin_l), .high_gate_out(gate_h), .low_gate_out(gate_l));

  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    @(posedge clock_in);
    while (hready !== 1'b1 && k < 50) begin
      k++;
      @(posedge clock_in);
    end
    if (k == 50) begin
      n_mismatch++;
      $display("BAD hready expected 1 seen %b", hready);
      wrap_up();
    end
  endtask

  // Zero-wait slave, but the master still waits on hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= ppo_pkg::HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    check_word("hresp", {31'h0, ppo_pkg::HRESP_OKAY}, {31'h0, hresp});
  endtask

  task automatic cfg(input logic [31:0] cv, input logic [31:0] fv);
    ctrl = cv;
    fctl = fv;
    bus(1'b1, ppo_pkg::OFS_PAIR_CTRL, cv);
    bus(1'b1, ppo_pkg::OFS_FAULT_CTRL, fv);
  endtask

  task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic check_pins(input string n, input logic [1:0] e, input logic [1:0] s);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %b seen %b", n, e, s);
    end
  endtask

  // Priority fault, override, generator; polarity last
  function automatic logic [1:0] exp_pins(input logic h, input logic l, input logic fa);
    logic [1:0] v;
    v[1] = ctrl[9] ? ctrl[7] : h;
    v[0] = ctrl[8] ? ctrl[6] : ((ctrl[11:10] == 2'h1) ? h : l);
    if (fa && fctl[1:0] != ppo_pkg::FLT_MODE_DISABLED) v = ctrl[5:4];
    return v ^ ctrl[13:12];
  endfunction

  task automatic apply(input logic h, input logic l, input logic fa);
    logic [1:0] e;
    @(posedge clock_in);
    gh <= h;
    gl <= l;
    flt <= fa;
    @(posedge clock_in);
    #1;
    e = exp_pins(h, l, fa);
    check_pins("pins", e, {pin_h, pin_l});
    // Power stage latches the pins one edge later
    @(posedge clock_in);
    #1;
    check_pins("gates", e, {gate_h, gate_l});
  endtask

  initial begin
    seed = 32'h3430;
    n_mismatch = 0;
    total_checks = 0;
    rst_n_in = 1'b0;
    {hsel, hwrite, gh, gl, flt} = 5'h00;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'h0;
    hsize = 3'h2;
    ctrl = ppo_pkg::PAIR_CTRL_RST;
    fctl = ppo_pkg::FAULT_CTRL_RST;
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    bus(1'b0, ppo_pkg::OFS_PAIR_CTRL, 32'h0);
    check_word("pair reset", ppo_pkg::PAIR_CTRL_RST, rd);
    bus(1'b0, ppo_pkg::OFS_FAULT_CTRL, 32'h0);
    check_word("fault reset", ppo_pkg::FAULT_CTRL_RST, rd);
    // Fault ignored while disabled at reset
    apply(1'b1, 1'b0, 1'b1);
    bus(1'b0, ppo_pkg::OFS_STATUS, 32'h0);
    check_word("status", 32'h0000_000D, rd);
    bus(1'b0, 8'h0C, 32'h0);
    check_word("unmapped", 32'h0, rd);
    // Status is read only; a write there must leave the controls alone
    bus(1'b1, ppo_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    bus(1'b0, ppo_pkg::OFS_PAIR_CTRL, 32'h0);
    check_word("pair after status write", ppo_pkg::PAIR_CTRL_RST, rd);
    $display("test reset done");
    for (m = 0; m < 4; m++) begin
      cfg(32'(m) << 10, 32'h3);
      apply(1'b1, 1'b0, 1'b0);
      apply(1'b0, 1'b1, 1'b0);
      cfg(32'(m) << 12, 32'h3);
      apply(1'b1, 1'b0, 1'b0);
      apply(1'b0, 1'b1, 1'b0);
      cfg(32'h0300 | (32'(m) << 6), 32'h3);
      bus(1'b0, ppo_pkg::OFS_PAIR_CTRL, 32'h0);
      check_word("override field", ctrl, rd);
      apply(~ctrl[7], ~ctrl[6], 1'b0);
      cfg(32'h3380 | (32'(m) << 4), 32'(m % 3));
      apply(1'b1, 1'b1, 1'b1);
      apply(1'b1, 1'b1, 1'b0);
    end
    $display("test corners done");
    for (i = 0; i < 40; i++) begin
      c = $random(seed) & 32'h0000_3FF0;
      f = $random(seed) & 32'h0000_8003;
      cfg(c, f);
      bus(1'b0, ppo_pkg::OFS_PAIR_CTRL, 32'h0);
      check_word("pair ctrl", c, rd);
      bus(1'b0, ppo_pkg::OFS_FAULT_CTRL, 32'h0);
      check_word("fault ctrl", f, rd);
      for (m = 0; m < 4; m++) begin
        apply(1'($random(seed)), 1'($random(seed)), 1'($random(seed)));
      end
    end
    $display("test random done");
    wrap_up();
  end
endmodule // ppo_top_bench
